// [lsfh_pkg.sv]
// Purpose: shared constants, types and helpers of the lin slave frame handler
// Assumes: 100 MHz clock, 19.2 kbit/s link
// Notes: timing figures are kept in their own unit and converted here
package lsfh_pkg;
    // clock and link rate
    localparam int CLK_HZ = 100_000_000;
    localparam int BIT_RATE = 19_200;
    // nominal bit in clocks, rounded down
    localparam int BIT_CYC = CLK_HZ / BIT_RATE;
    // break is at least 11 dominant bits
    localparam int BREAK_BITS = 11;
    localparam int BREAK_CYC = BREAK_BITS * BIT_CYC;
    // longest frame in tenths of a bit (1.4 x 124 bits), rounded down
    localparam int FRAME_MAX_TENTHS = 1736;
    localparam int FRAME_MAX_CYC = FRAME_MAX_TENTHS * BIT_CYC / 10;
    // accepted deviation of the measured bit from nominal, percent
    localparam int SYNC_TOL_PCT = 14;
    // counter widths
    localparam int CNT_W = 20;
    localparam int FRM_W = 24;
    // error flag positions and reset value
    localparam int ERR_BIT = 0;
    localparam int ERR_HEADER = 1;
    localparam int ERR_DATA = 2;
    localparam int ERR_TIMEOUT = 3;
    localparam logic [7:0] ERR_RESET = 8'h00;
    // identifiers and data markers
    localparam logic [5:0] ID_DIAG = 6'h3C;
    localparam logic [7:0] APP_COMMAND_MARKER = 8'h80;
    localparam int ALL_NODES_BIT = 7;
    // command code that clears the flags; plain default
    localparam logic [6:0] FULL_STATUS_DEF = 7'h01;
    // data lengths
    localparam logic [3:0] LEN_2 = 4'h2;
    localparam logic [3:0] LEN_4 = 4'h4;
    localparam logic [3:0] LEN_8 = 4'h8;
    // command word layout {kind, id, command}
    localparam int CMD_W = 17;
    localparam int CMD_ID_LSB = 8;
    localparam int CMD_KIND_LSB = 14;
    localparam int FIFO_DEPTH = 4;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_BREAK = 3'b001,
        ST_SYNC = 3'b010,
        ST_WAIT = 3'b011,
        ST_BYTE = 3'b100,
        ST_PUSH = 3'b101
    } lsfh_state_t;

    typedef enum logic [2:0] {
        K_NONE = 3'b000,
        K_DIAG = 3'b001,
        K_ADDR = 3'b010,
        K_APP = 3'b011,
        K_NODE = 3'b100
    } lsfh_kind_t;

    // both parity bits of a protected identifier
    function automatic logic lsfh_parity_ok(input logic [7:0] id);
        logic id_even_parity;
        logic id_odd_parity;
        id_even_parity = id[0] ^ id[1] ^ id[2] ^ id[4];
        id_odd_parity = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
        return (id[6] == id_even_parity) && (id[7] == id_odd_parity);
    endfunction : lsfh_parity_ok

    // number of data bytes from the two length bits
    function automatic logic [3:0] lsfh_len(input logic id_length_high,
                                            input logic id_length_low);
        logic [3:0] n;
        n = LEN_2;
        if (id_length_high) begin
            n = id_length_low ? LEN_8 : LEN_4;
        end
        return n;
    endfunction : lsfh_len
endpackage : lsfh_pkg

// [lsfh_fifo_if.sv]
// Purpose: carrier between the frame handler and its command fifo
// Assumes: single clock
// Notes: valid/ready on both sides
`timescale 1ns/1ps
interface lsfh_fifo_if #(parameter int W = 8);
    logic push_valid;
    logic push_ready;
    logic [W-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [W-1:0] pop_data;
    modport src (output push_valid, output push_data, input push_ready);
    modport fifo (input push_valid, input push_data, output push_ready,
                  output pop_valid, output pop_data, input pop_ready);
    modport sink (input pop_valid, input pop_data, output pop_ready);
endinterface : lsfh_fifo_if

// [lsfh_fifo.sv]
// Purpose: small shifting fifo for accepted commands
// Assumes: single clock, push and pop may coincide
// Notes: head word and valid come straight from flip-flops
`timescale 1ns/1ps
module lsfh_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 4
)(
    input wire logic clk,
    input wire logic rst,
    lsfh_fifo_if.fifo f
);
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || W < 1) begin : g_bad_cfg
        $error("fifo depth below two or width below one");
    end

    logic [W-1:0] mem_q [DEPTH];
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic valid_q;

    // handshakes; full is honest so the source really stalls
    wire push = f.push_valid & f.push_ready;
    wire pop = f.pop_valid & f.pop_ready;
    wire [CW-1:0] wr_idx = pop ? cnt_q - CW'(1) : cnt_q;
    assign f.push_ready = cnt_q != CW'(DEPTH);
    assign f.pop_valid = valid_q;
    assign f.pop_data = mem_q[0];
    assign cnt_d = cnt_q + CW'(push) - CW'(pop);

    // each entry shifts down on pop, takes the new word at the tail
    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
        wire [W-1:0] above = (i < DEPTH - 1) ? mem_q[(i + 1) % DEPTH] : mem_q[i];
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                mem_q[i] <= '0;
            end else if (push && wr_idx == CW'(i)) begin
                mem_q[i] <= f.push_data;
            end else if (pop) begin
                mem_q[i] <= above;
            end
        end
    end

    // occupancy and registered valid
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            valid_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            valid_q <= cnt_d != '0;
        end
    end
endmodule : lsfh_fifo

// [lsfh_top.sv]
// Purpose: protocol handler of a lin slave node, receive, check, respond
// Assumes: one lin master; bus pin and address pins are asynchronous
// Notes: the bit period is relearned from every sync field
`timescale 1ns/1ps
module lsfh_top #(
    parameter int BIT_CYC_NOM = lsfh_pkg::BIT_CYC,
    parameter int BREAK_CYC_P = lsfh_pkg::BREAK_CYC,
    parameter int FRAME_MAX_P = lsfh_pkg::FRAME_MAX_CYC,
    parameter logic [6:0] FULL_STATUS_CODE = lsfh_pkg::FULL_STATUS_DEF
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic lin_rx,
    output logic lin_tx_o,
    output logic lin_tx_oe_n,
    input wire logic hardwired_addr_pin_a,
    input wire logic hardwired_addr_pin_b,
    input wire logic hardwired_addr_pin_c,
    input wire logic [3:0] stored_addr_bits,
    input wire logic [5:0] cfg_id_addr_cmd,
    input wire logic [5:0] cfg_id_app_cmd,
    input wire logic [5:0] cfg_id_node_cmd,
    input wire logic resp_en,
    input wire logic [5:0] resp_id,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_taken,
    output logic cmd_valid,
    output logic [lsfh_pkg::CMD_W-1:0] cmd_word,
    input wire logic cmd_ready,
    output logic [7:0] link_error_flags
);
    import lsfh_pkg::*;

    if (BIT_CYC_NOM < 16 || BIT_CYC_NOM * 9 >= 2 ** CNT_W ||
        BREAK_CYC_P >= 2 ** CNT_W || FRAME_MAX_P >= 2 ** FRM_W ||
        FRAME_MAX_P < 2) begin : g_bad_cfg
        $error("timing parameters do not fit the counters");
    end

    localparam logic [CNT_W-1:0] BIT_NOM = CNT_W'(BIT_CYC_NOM);
    localparam logic [CNT_W-1:0] BIT_LO = CNT_W'(BIT_CYC_NOM * (100 - SYNC_TOL_PCT) / 100);
    localparam logic [CNT_W-1:0] BIT_HI = CNT_W'(BIT_CYC_NOM * (100 + SYNC_TOL_PCT) / 100);
    localparam logic [CNT_W-1:0] BRK = CNT_W'(BREAK_CYC_P);
    localparam logic [FRM_W-1:0] FRM_LAST = FRM_W'(FRAME_MAX_P - 1);

    // pin synchronisers, first stage read only by the second
    logic rx_meta_q;
    logic rx_q;
    logic rx_prev_q;
    logic [2:0] hw_meta_q;
    logic [2:0] hw_q;

    lsfh_state_t st_q, st_d;
    lsfh_kind_t kind_q, kind_d;
    logic [CNT_W-1:0] cnt_q, cnt_d, bit_len_q, bit_len_d;
    logic [FRM_W-1:0] frm_q, frm_d;
    logic [3:0] bit_idx_q, bit_idx_d, byte_no_q, byte_no_d, need_q, need_d;
    logic [7:0] sh_q, sh_d, sum_q, sum_d, tx_sh_q, err_q, err_d;
    logic [7:0] data_q [3];
    logic [7:0] data_d [3];
    logic [5:0] id_q, id_d;
    logic [2:0] edges_q, edges_d;
    logic tx_mode_q, tx_mode_d, oe_n_q, oe_n_d, tx_take;
    logic tx_taken_q;
    logic [CMD_W-1:0] cmd_q, cmd_d;

    lsfh_fifo_if #(.W(CMD_W)) cmd_if ();

    // bit timing decode
    wire rx_fall = rx_prev_q & ~rx_q;
    wire half = cnt_q == (bit_len_q >> 1);
    wire bit_end = cnt_q == bit_len_q - CNT_W'(1);
    wire sample = (st_q == ST_BYTE) && half;
    wire byte_done = sample && (bit_idx_q == 4'h9);
    wire [CNT_W-1:0] meas = cnt_q >> 3;
    wire sync_ok = (meas >= BIT_LO) && (meas <= BIT_HI);
    wire sync_end = (st_q == ST_SYNC) && rx_fall && (edges_q == 3'h4);
    wire sync_bad = sync_end && !sync_ok;

    // identifier decode
    wire [5:0] id6 = sh_q[5:0];
    wire id_length_high = sh_q[5];
    wire id_length_low = sh_q[4];
    wire parity_ok = lsfh_parity_ok(sh_q);
    wire [3:0] id_len = lsfh_len(id_length_high, id_length_low);
    wire resp_hit = resp_en && (id6 == resp_id);
    wire is_id = byte_no_q == 4'h0;
    wire is_ck = byte_no_q == need_q + 4'h1;
    lsfh_kind_t id_kind;
    assign id_kind = (id6 == ID_DIAG) ? K_DIAG :
                     (id6 == cfg_id_addr_cmd) ? K_ADDR :
                     (id6 == cfg_id_app_cmd) ? K_APP :
                     (id6 == cfg_id_node_cmd) ? K_NODE : K_NONE;

    // frame checks; checksum folds every carry back in
    wire [8:0] sum9 = {1'b0, sum_q} + {1'b0, sh_q};
    wire [7:0] sum_next = sum9[7:0] + {7'h00, sum9[8]};
    wire rx_byte = byte_done && !tx_mode_q;
    wire stop_bad = rx_byte && !rx_q;
    wire hdr_bad = rx_byte && rx_q && is_id && !parity_ok;
    wire ck_end = rx_byte && rx_q && is_ck;
    wire ck_bad = ~sum_q != sh_q;
    wire len_bad = (kind_q == K_DIAG && need_q != LEN_8) ||
                   (kind_q == K_ADDR && need_q == LEN_8) ||
                   (kind_q == K_NODE && need_q != LEN_2);
    wire echo_bad = sample && tx_mode_q && (rx_q != oe_n_q);
    wire active = (st_q == ST_SYNC) || (st_q == ST_WAIT) || (st_q == ST_BYTE);
    wire timeout = active && (frm_q == FRM_LAST);

    // addressing: pins form the top three bits
    wire [6:0] own_addr = {hw_q[0], hw_q[1], hw_q[2], stored_addr_bits};
    wire [7:0] addr_byte = (kind_q == K_DIAG) ? data_q[2] : data_q[1];
    wire addr_hit = !addr_byte[ALL_NODES_BIT] || (addr_byte[6:0] == own_addr);
    // in a diagnostic frame byte 0 must carry the marker, which also keeps bit 7 high
    wire marker_ok = data_q[0] == APP_COMMAND_MARKER;
    wire [7:0] cmd_byte = (kind_q == K_DIAG) ? data_q[1] : data_q[0];
    wire want = (kind_q == K_DIAG) ? (marker_ok && addr_hit) :
                (kind_q == K_ADDR) ? addr_hit :
                (kind_q == K_APP) || (kind_q == K_NODE);
    wire accept = ck_end && !ck_bad && !len_bad && want;
    wire full_status_query = accept && (cmd_byte[6:0] == FULL_STATUS_CODE);

    // flag sets; a set in the clearing cycle survives
    wire [3:0] set_v = {timeout, stop_bad || (ck_end && (ck_bad || len_bad)),
                        sync_bad || hdr_bad, echo_bad};
    assign err_d = (err_q & ~{8{full_status_query}}) | {4'h0, set_v};

    assign cmd_if.push_valid = st_q == ST_PUSH;
    assign cmd_if.push_data = cmd_q;
    assign cmd_if.pop_ready = cmd_ready;
    assign cmd_valid = cmd_if.pop_valid;
    assign cmd_word = cmd_if.pop_data;
    assign lin_tx_oe_n = oe_n_q;
    assign tx_taken = tx_taken_q;
    assign link_error_flags = err_q;

    // frame sequencer
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q + CNT_W'(1);
        bit_len_d = bit_len_q;
        frm_d = active ? frm_q + FRM_W'(1) : '0;
        bit_idx_d = bit_idx_q;
        byte_no_d = byte_no_q;
        need_d = need_q;
        sh_d = sh_q;
        sum_d = sum_q;
        data_d = data_q;
        id_d = id_q;
        kind_d = kind_q;
        edges_d = edges_q;
        tx_mode_d = tx_mode_q;
        oe_n_d = oe_n_q;
        tx_take = 1'b0;
        cmd_d = cmd_q;
        case (st_q)
            ST_IDLE: begin
                cnt_d = '0;
                oe_n_d = 1'b1;
                tx_mode_d = 1'b0;
                if (!rx_q) begin
                    st_d = ST_BREAK;
                end
            end
            ST_BREAK: begin
                if (&cnt_q) begin
                    cnt_d = cnt_q;
                end
                if (rx_q) begin
                    cnt_d = '0;
                    edges_d = 3'h0;
                    st_d = (cnt_q >= BRK) ? ST_SYNC : ST_IDLE;
                end
            end
            ST_SYNC: begin
                if (rx_fall) begin
                    edges_d = edges_q + 3'h1;
                    if (edges_q == 3'h0) begin
                        cnt_d = '0;
                    end
                    if (sync_end) begin
                        // five falling edges span eight bits
                        bit_len_d = meas;
                        byte_no_d = 4'h0;
                        sum_d = 8'h00;
                        st_d = sync_ok ? ST_WAIT : ST_IDLE;
                    end
                end
            end
            ST_WAIT: begin
                cnt_d = '0;
                bit_idx_d = 4'h0;
                if (tx_mode_q) begin
                    // only a header naming our response starts a send
                    if (tx_valid) begin
                        tx_take = 1'b1;
                        oe_n_d = 1'b0;
                        st_d = ST_BYTE;
                    end
                end else if (rx_fall) begin
                    st_d = ST_BYTE;
                end
            end
            ST_BYTE: begin
                if (bit_end) begin
                    cnt_d = '0;
                    bit_idx_d = bit_idx_q + 4'h1;
                    if (tx_mode_q) begin
                        oe_n_d = (bit_idx_q == 4'h8) ? 1'b1 : tx_sh_q[bit_idx_q[2:0]];
                    end
                end
                if (sample) begin
                    if (bit_idx_q >= 4'h1 && bit_idx_q <= 4'h8) begin
                        sh_d = {rx_q, sh_q[7:1]};
                    end
                    if (bit_idx_q == 4'h0 && rx_q && !tx_mode_q) begin
                        st_d = ST_WAIT;
                    end
                    if (echo_bad) begin
                        st_d = ST_IDLE;
                        oe_n_d = 1'b1;
                    end else if (byte_done && tx_mode_q) begin
                        byte_no_d = byte_no_q + 4'h1;
                        st_d = is_ck ? ST_IDLE : ST_WAIT;
                    end else if (byte_done) begin
                        byte_no_d = byte_no_q + 4'h1;
                        st_d = ST_WAIT;
                        if (!rx_q || (is_id && !parity_ok)) begin
                            st_d = ST_IDLE;
                        end else if (is_id) begin
                            need_d = id_len;
                            id_d = id6;
                            kind_d = id_kind;
                            tx_mode_d = resp_hit;
                            if (!resp_hit && id_kind == K_NONE) begin
                                st_d = ST_IDLE;
                            end
                        end else if (is_ck) begin
                            cmd_d = {kind_q, id_q, cmd_byte};
                            st_d = accept ? ST_PUSH : ST_IDLE;
                        end else begin
                            sum_d = sum_next;
                            if (byte_no_q <= 4'h3) begin
                                data_d[byte_no_q[1:0] - 2'h1] = sh_q;
                            end
                        end
                    end
                end
            end
            ST_PUSH: begin
                // a full fifo holds the sequencer here
                if (cmd_if.push_ready) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
        if (timeout) begin
            st_d = ST_IDLE;
            oe_n_d = 1'b1;
        end
    end

    // synchronisers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_meta_q <= 1'b1;
            rx_q <= 1'b1;
            rx_prev_q <= 1'b1;
            hw_meta_q <= 3'h0;
            hw_q <= 3'h0;
        end else begin
            rx_meta_q <= lin_rx;
            rx_q <= rx_meta_q;
            rx_prev_q <= rx_q;
            hw_meta_q <= {hardwired_addr_pin_c, hardwired_addr_pin_b, hardwired_addr_pin_a};
            hw_q <= hw_meta_q;
        end
    end

    // sequencer and counters
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= ST_IDLE;
            cnt_q <= '0;
            bit_len_q <= BIT_NOM;
            frm_q <= '0;
            bit_idx_q <= 4'h0;
            byte_no_q <= 4'h0;
            need_q <= LEN_2;
            edges_q <= 3'h0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            bit_len_q <= bit_len_d;
            frm_q <= frm_d;
            bit_idx_q <= bit_idx_d;
            byte_no_q <= byte_no_d;
            need_q <= need_d;
            edges_q <= edges_d;
        end
    end

    // frame contents
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sh_q <= 8'h00;
            sum_q <= 8'h00;
            data_q <= '{default: 8'h00};
            id_q <= 6'h00;
            kind_q <= K_NONE;
            cmd_q <= '0;
        end else begin
            sh_q <= sh_d;
            sum_q <= sum_d;
            data_q <= data_d;
            id_q <= id_d;
            kind_q <= kind_d;
            cmd_q <= cmd_d;
        end
    end

    // transmit side and error register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_mode_q <= 1'b0;
            oe_n_q <= 1'b1;
            lin_tx_o <= 1'b0;
            tx_taken_q <= 1'b0;
            tx_sh_q <= 8'h00;
            err_q <= ERR_RESET;
        end else begin
            tx_mode_q <= tx_mode_d;
            oe_n_q <= oe_n_d;
            lin_tx_o <= 1'b0;
            tx_taken_q <= tx_take;
            tx_sh_q <= tx_take ? tx_data : tx_sh_q;
            err_q <= err_d;
        end
    end

    lsfh_fifo #(.W(CMD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst(rst),
        .f(cmd_if)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_bad_echo;
        sample && tx_mode_q ##0 rx_q != oe_n_q;
    endsequence
    sequence s_dropped;
        st_q == ST_IDLE ##1 !cmd_if.push_valid;
    endsequence

    a_hdr_parity: assert property (hdr_bad |=> err_q[ERR_HEADER] && st_q == ST_IDLE)
        else $error("bad identifier parity not flagged");
    a_sync_reject: assert property (sync_bad |=> err_q[ERR_HEADER] ##0 st_q == ST_IDLE)
        else $error("malformed sync not flagged");
    a_cksum_check: assert property ((ck_end && ck_bad) |=> err_q[ERR_DATA] and s_dropped)
        else $error("checksum mismatch not caught");
    a_len_error: assert property ((ck_end && len_bad) |=> err_q[ERR_DATA] ##0 s_dropped)
        else $error("wrong length not flagged");
    a_frame_timeout: assert property (timeout |=> err_q[ERR_TIMEOUT] && st_q == ST_IDLE)
        else $error("overlong frame not flagged");
    a_echo_check: assert property (s_bad_echo |=> err_q[ERR_BIT] && oe_n_q ##1 oe_n_q)
        else $error("bit mismatch not flagged or drive kept");
    a_query_clear: assert property ((full_status_query && set_v == 4'h0) |=> err_q == ERR_RESET)
        else $error("flags not cleared by status query");
    a_sticky_flags: assert property (!$past(full_status_query) |-> (($past(err_q) & ~err_q) == 8'h00))
        else $error("error flag dropped without query");
    a_len_decode: assert property ((rx_byte && rx_q && is_id && parity_ok) |=>
        (need_q == LEN_8) == $past(sh_q[5:4] == 2'b11))
        else $error("data length decoded wrongly");
    a_slave_only: assert property (!oe_n_q |-> tx_mode_q && $past(st_q != ST_IDLE, 2))
        else $error("bus driven outside a response");
    a_addr_filter: assert property ((ck_end && kind_q == K_ADDR && data_q[1][7] &&
        data_q[1][6:0] != own_addr) |=> s_dropped)
        else $error("frame for another node accepted");
    a_diag_marker: assert property ((ck_end && kind_q == K_DIAG && !marker_ok) |=> st_q != ST_PUSH)
        else $error("diagnostic frame without marker accepted");
endmodule : lsfh_top

// [lsfh_lin_master.sv]
// Purpose: lin master model that drives the bus level
// Assumes: bit time of 32 clocks
// Notes: idle bus stays recessive through the pull-up
`timescale 1ns/1ps
module lsfh_lin_master (
    input wire logic clk,
    output logic line
);
    initial line = 1'h1;
    // one bit per 32 clocks, lsb first
    task automatic bits(input logic [9:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            line <= v[i];
            repeat (32) @(posedge clk);
        end
    endtask : bits
    // header only: break, delimiter, sync, protected id; bp spoils parity
    task automatic header(input logic [5:0] id, input logic bp);
        bits(10'h000, 10);
        bits(10'h3FC, 4);
        bits(10'h2AA, 10);
        bits({1'h1, ~(id[1] ^ id[3] ^ id[4] ^ id[5]), ^{id[0], id[1], id[2], id[4], bp}, id, 1'h0}, 10);
    endtask : header
    // full frame; bp spoils parity, bc spoils the check byte
    task automatic frame(input logic [5:0] id, input logic [7:0] d[8], input int n,
                         input logic bp, input logic bc);
        logic [8:0] s;
        s = 9'h000;
        header(id, bp);
        for (int i = 0; i < n; i++) begin
            bits({1'h1, d[i], 1'h0}, 10);
            s = s[7:0] + d[i];
            s = s[7:0] + s[8];
        end
        bits({1'h1, ~s[7:1], ~s[0] ^ bc, 1'h0}, 10);
        bits(10'h3FF, 2);
    endtask : frame
endmodule : lsfh_lin_master

// [tb_lsfh_top.sv]
// Purpose: self-checking bench of the lin slave frame handler
// Assumes: bit time shortened to 32 clocks
// Notes: accepted commands are matched in order through a queue
`timescale 1ns/1ps
module tb_lsfh_top;
    import lsfh_pkg::*;
    logic clk = 1'h0, rst = 1'h1, m_line, oe_n, cv;
    logic [16:0] cw;
    logic [7:0] flags;
    logic [15:0] lf = 16'h2A12;
    logic [16:0] q[$];
    logic [7:0] d[8];
    logic [6:0] own = 7'h00;
    logic r_en = 1'h0, tx_v = 1'h0, tx_tk, c_rdy = 1'h0;
    logic [5:0] r_id = 6'h00;
    logic [7:0] tx_d = 8'h00;
    logic [15:0] lf_r = 16'h2A12;
    int n_fail = 0, num_checks = 0;
    always #5 clk = ~clk;
    lsfh_lin_master u_mst (.clk(clk), .line(m_line));
    lsfh_top #(.BIT_CYC_NOM(32), .BREAK_CYC_P(352), .FRAME_MAX_P(6000)) u_dut (
        .clk(clk), .rst(rst), .lin_rx(m_line & oe_n), .lin_tx_o(), .lin_tx_oe_n(oe_n),
        .hardwired_addr_pin_a(own[6]), .hardwired_addr_pin_b(own[5]),
        .hardwired_addr_pin_c(own[4]), .stored_addr_bits(own[3:0]),
        .cfg_id_addr_cmd(6'h21), .cfg_id_app_cmd(6'h02), .cfg_id_node_cmd(6'h05),
        .resp_en(r_en), .resp_id(r_id), .tx_valid(tx_v), .tx_data(tx_d), .tx_taken(tx_tk),
        .cmd_valid(cv), .cmd_word(cw), .cmd_ready(c_rdy), .link_error_flags(flags));
    // next value of the bench's random source
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next
    // random pop readiness, so a waiting command has to stand
    always @(posedge clk) begin
        lf_r <= lfsr_next(lf_r);
        c_rdy <= lf_r[3];
    end
    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic print_verdict;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict
    // note the expected command, send the frame, wait a bounded time for the pop
    task automatic run(input logic [5:0] id, input int n, input logic bp, input logic bc,
                       input logic push, input logic [16:0] exp);
        int k;
        if (push) q.push_back(exp);
        u_mst.frame(id, d, n, bp, bc);
        for (k = 0; k < 300 && q.size() > 0; k++) @(posedge clk);
        if (k == 300) begin
            n_fail++;
            print_verdict();
        end
    endtask : run
    // header for our response id, then offer n bytes; spoil pulls a sent 1 dominant
    task automatic respond(input logic [5:0] id, input int n, input logic spoil);
        int k;
        r_id <= id;
        r_en <= 1'h1;
        u_mst.header(id, 1'h0);
        tx_v <= 1'h1;
        for (int b = 0; b < n; b++) begin
            lf = lfsr_next(lf);
            tx_d <= spoil ? 8'hFF : lf[7:0];
            k = 0;
            do begin
                @(posedge clk);
                k++;
            end while (k < 2000 && tx_tk !== 1'h1);
            check({16'h0000, tx_tk}, 17'h00001);
        end
        tx_v <= 1'h0;
        if (spoil) u_mst.bits(10'h3FC, 4);
        repeat (400) @(posedge clk);
        r_en <= 1'h0;
    endtask : respond
    // an unnoted command compares against an impossible word
    always @(posedge clk) begin
        if (cv === 1'h1 && c_rdy === 1'h1) check(cw, q.size() ? q.pop_front() : 17'h1FFFF);
    end
    initial begin
        for (int i = 0; i < 8; i++) begin
            lf = lfsr_next(lf);
            d[i] = lf[7:0];
        end
        repeat (12) @(posedge clk) own <= lf[14:8];
        rst <= 1'h0;
        repeat (4) @(posedge clk);
        check({9'h000, flags}, {9'h000, ERR_RESET});
        check({16'h0000, oe_n}, 17'h00001);
        d[0][1:0] = 2'h2;
        run(6'h02, 2, 1'h0, 1'h0, 1'h1, {K_APP, 6'h02, d[0]});
        d[1] = {1'h1, own};
        run(6'h21, 4, 1'h0, 1'h0, 1'h1, {K_ADDR, 6'h21, d[0]});
        d[1] = {1'h1, ~own};
        run(6'h21, 4, 1'h0, 1'h0, 1'h0, 17'h00000);
        d[0] = APP_COMMAND_MARKER;
        d[2] = {1'h0, ~own};
        run(ID_DIAG, 8, 1'h0, 1'h0, 1'h1, {K_DIAG, ID_DIAG, d[1]});
        respond(6'h10, 3, 1'h0);
        check({9'h000, flags}, 17'h00000);
        respond(6'h10, 1, 1'h1);
        check({9'h000, flags}, 17'h00001);
        run(6'h02, 2, 1'h0, 1'h1, 1'h0, 17'h00000);
        check({9'h000, flags}, 17'h00005);
        run(6'h02, 2, 1'h1, 1'h0, 1'h0, 17'h00000);
        check({9'h000, flags}, 17'h00007);
        d[0] = {1'h0, FULL_STATUS_DEF};
        run(6'h02, 2, 1'h0, 1'h0, 1'h1, {K_APP, 6'h02, d[0]});
        check({9'h000, flags}, 17'h00000);
        print_verdict();
    end
endmodule : tb_lsfh_top
